// *** hw/icc_device.sv ***
// Purpose: Flash device end of impedance calibration control
// Assumes: host end on the same mclk; commands arrive as one-cycle strobes
// Notes: ready/busy low across calibration, transfer and reset
// How it works
// - F9h starts long calibration of both
// - D9h starts short drift-correcting calibration
// - Long calibration at power-up, accepted whenever idle
// - Copy engine codes into driver and termination
// - Long run plus transfer within long time
// - Short run corrects at least 1.5 percent
// - Host keeps data bus quiet during calibration
// - Host keeps all channels quiet meanwhile
// - Calibration current off once finished
// - No array operations while calibrating
// - Data outputs high impedance during calibration
// - Ready/busy low for calibration time
// - Shared busy: host waits delay plus long or short time
// - Reset aborts long, restores factory codes
// - Reset aborts short, restores vendor codes
// - Aborting reset completes under 10 us
// - Host never overlaps shared-resistor calibrations
// - Calibration optional on DDR interfaces
`timescale 1ns/1ns
module icc_device (
    input wire logic mclk,
    input wire logic sys_rst,
    icc_if.device link,
    input wire logic cmp_above,
    input wire logic array_req,
    output logic array_go,
    output logic cal_current_en,
    output logic cal_valid,
    output logic [icc_pkg::CODE_W-1:0] drv_code,
    output logic [icc_pkg::CODE_W-1:0] odt_code
);
    import icc_pkg::*;

    typedef enum logic [1:0] {
        DEV_IDLE = 2'b00,
        DEV_CAL = 2'b01,
        DEV_XFER = 2'b10,
        DEV_RESET = 2'b11
    } icc_dev_state_t;

    // Engine budgets leave one cycle for the done flag and the transfer cycles
    localparam logic [CNT_W-1:0] LONG_ENG_CYCLES = LONG_CAL_CYCLES - XFER_CYCLES - 16'h0001;
    localparam logic [CNT_W-1:0] SHORT_ENG_CYCLES = SHORT_CAL_CYCLES - XFER_CYCLES - 16'h0001;

    icc_dev_state_t state_reg, state_next;
    logic [CNT_W-1:0] cnt_reg, cnt_next;
    logic long_reg, long_next;
    logic init_reg, init_next;
    logic rb_reg, rb_next;
    logic oe_reg, oe_next;
    logic [7:0] dq_reg, dq_next;
    logic [CODE_W-1:0] drv_reg, drv_next, odt_reg, odt_next;
    logic valid_reg, valid_next;
    logic go_reg, go_next;
    logic eng_start, eng_long, eng_abort;
    logic [CNT_W-1:0] eng_cycles;
    logic eng_done;
    logic [CODE_W-1:0] eng_drv, eng_odt;
    logic start_long, start_short, reset_cmd;

    // Command decode
    assign start_long = init_reg || (link.cmd_we && (link.cmd_code == CMD_LONG_CAL));
    assign start_short = link.cmd_we && (link.cmd_code == CMD_SHORT_CAL);
    assign reset_cmd = link.cmd_we && icc_is_reset(link.cmd_code);

    icc_cal_engine u_engine (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .start(eng_start),
        .long_mode(eng_long),
        .abort(eng_abort),
        .cycles(eng_cycles),
        .cmp_above(cmp_above),
        .done(eng_done),
        .current_en(cal_current_en),
        .drv_code(eng_drv),
        .odt_code(eng_odt)
    );

    // Sequencer next state
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        long_next = long_reg;
        init_next = init_reg;
        rb_next = rb_reg;
        oe_next = 1'b0;
        dq_next = dq_reg;
        drv_next = drv_reg;
        odt_next = odt_reg;
        valid_next = valid_reg;
        go_next = 1'b0;
        eng_start = 1'b0;
        eng_long = 1'b0;
        eng_abort = 1'b0;
        eng_cycles = SHORT_ENG_CYCLES;
        case (state_reg)
            DEV_IDLE: begin
                rb_next = 1'b1;
                if (start_long) begin
                    // Initial and on-demand long calibration
                    init_next = 1'b0;
                    eng_start = 1'b1;
                    eng_long = 1'b1;
                    eng_cycles = LONG_ENG_CYCLES; // Fits the long budget
                    long_next = 1'b1;
                    rb_next = 1'b0; // Busy from the next cycle
                    state_next = DEV_CAL;
                end else if (start_short) begin
                    // Periodic short calibration
                    eng_start = 1'b1;
                    eng_cycles = SHORT_ENG_CYCLES;
                    long_next = 1'b0;
                    rb_next = 1'b0;
                    state_next = DEV_CAL;
                end else if (reset_cmd) begin
                    rb_next = 1'b0;
                    cnt_next = RESET_CYCLES;
                    state_next = DEV_RESET;
                end else if (link.cmd_we && (link.cmd_code == CMD_READ_STATUS)) begin
                    // Status answered only while idle
                    oe_next = 1'b1;
                    dq_next = 8'h00;
                    dq_next[STAT_READY_BIT] = 1'b1;
                    dq_next[STAT_CAL_VALID_BIT] = valid_reg;
                end else begin
                    go_next = array_req; // Array only when not calibrating
                end
            end
            DEV_CAL: begin
                rb_next = 1'b0;
                if (reset_cmd) begin
                    eng_abort = 1'b1;
                    valid_next = 1'b0;
                    if (long_reg) begin
                        drv_next = FACTORY_DRV_CODE;
                        odt_next = FACTORY_ODT_CODE;
                    end else begin
                        drv_next = VENDOR_DRV_CODE;
                        odt_next = VENDOR_ODT_CODE;
                    end
                    cnt_next = RESET_CYCLES; // Bounded reset time
                    state_next = DEV_RESET;
                end else if (eng_done) begin
                    state_next = DEV_XFER;
                end
            end
            DEV_XFER: begin
                // Load calibrated codes into the pads
                drv_next = eng_drv;
                odt_next = eng_odt;
                valid_next = 1'b1;
                rb_next = 1'b1; // Ready again after transfer
                state_next = DEV_IDLE;
            end
            DEV_RESET: begin
                if (cnt_reg <= 16'h0001) begin
                    cnt_next = '0;
                    rb_next = 1'b1;
                    state_next = DEV_IDLE;
                end else begin
                    cnt_next = cnt_reg - 1'b1;
                end
            end
            default: begin
                rb_next = 1'b1;
                state_next = DEV_IDLE;
            end
        endcase
    end

    // Sequencer registers
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state_reg <= DEV_IDLE;
            cnt_reg <= '0;
            long_reg <= 1'b0;
            init_reg <= 1'b1;
            rb_reg <= 1'b0;
            oe_reg <= 1'b0;
            dq_reg <= 8'h00;
            drv_reg <= FACTORY_DRV_CODE;
            odt_reg <= FACTORY_ODT_CODE;
            valid_reg <= 1'b0;
            go_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            long_reg <= long_next;
            init_reg <= init_next;
            rb_reg <= rb_next;
            oe_reg <= oe_next;
            dq_reg <= dq_next;
            drv_reg <= drv_next;
            odt_reg <= odt_next;
            valid_reg <= valid_next;
            go_reg <= go_next;
        end
    end

    // Outputs straight from registers
    assign link.rb_n = rb_reg;
    assign link.dev_dq_oe = oe_reg;
    assign link.dev_dq_out = dq_reg;
    assign array_go = go_reg;
    assign cal_valid = valid_reg;
    assign drv_code = drv_reg;
    assign odt_code = odt_reg;
endmodule : icc_device

// *** hw/icc_pkg.sv ***
// Purpose: Shared constants for the impedance calibration control ends
// Assumes: one clock mclk at 250 MHz, synchronous active-high reset
// Notes: calibration times are plain defaults; adjust per process
package icc_pkg;
    // Command codes on the channel
    localparam logic [7:0] CMD_LONG_CAL = 8'hf9;
    localparam logic [7:0] CMD_SHORT_CAL = 8'hd9;
    localparam logic [7:0] CMD_RESET = 8'hff;
    localparam logic [7:0] CMD_SYNC_RESET = 8'hfc;
    localparam logic [7:0] CMD_LUN_RESET = 8'hfa;
    localparam logic [7:0] CMD_READ_STATUS = 8'h70;

    // Widths
    localparam int CODE_W = 6;
    localparam int CNT_W = 16;

    // Times in ns and the derived cycle counts
    localparam int CLK_PERIOD_NS = 4;
    localparam int LONG_CAL_TIME_NS = 1000;
    localparam int SHORT_CAL_TIME_NS = 256;
    localparam int BUSY_ASSERT_DELAY_NS = 100;
    localparam int RESET_TIME_NS = 2000; // Well below the 10 us abort limit
    localparam logic [CNT_W-1:0] LONG_CAL_CYCLES = CNT_W'(LONG_CAL_TIME_NS / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] SHORT_CAL_CYCLES = CNT_W'(SHORT_CAL_TIME_NS / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] RESET_CYCLES = CNT_W'(RESET_TIME_NS / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] XFER_CYCLES = 16'h0001;
    // Host-side least waits round up
    localparam logic [CNT_W-1:0] BUSY_ASSERT_CYCLES =
        CNT_W'((BUSY_ASSERT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] HOST_LONG_WAIT =
        CNT_W'((LONG_CAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] HOST_SHORT_WAIT =
        CNT_W'((SHORT_CAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // Impedance codes
    localparam logic [CODE_W-1:0] CODE_MID = 6'h20;
    localparam logic [CODE_W-1:0] FACTORY_DRV_CODE = 6'h20;
    localparam logic [CODE_W-1:0] FACTORY_ODT_CODE = 6'h20;
    localparam logic [CODE_W-1:0] VENDOR_DRV_CODE = 6'h1c;
    localparam logic [CODE_W-1:0] VENDOR_ODT_CODE = 6'h1c;

    // Status byte fields
    localparam int STAT_READY_BIT = 6;
    localparam int STAT_CAL_VALID_BIT = 1;

    // Any of the three reset codes
    function automatic logic icc_is_reset(input logic [7:0] code);
        icc_is_reset = (code == CMD_RESET) || (code == CMD_SYNC_RESET) ||
            (code == CMD_LUN_RESET);
    endfunction : icc_is_reset
endpackage : icc_pkg

// *** hw/icc_if.sv ***
// Purpose: Channel between host controller and flash device end
// Assumes: both ends on mclk; host drives commands, device drives status
// Notes: no resolved dq wire; the host samples dev_dq_out while dev_dq_oe is high
`timescale 1ns/1ns
interface icc_if;
    logic cmd_we;
    logic [7:0] cmd_code;
    logic rb_n;
    logic [7:0] dev_dq_out;
    logic dev_dq_oe;

    modport device (input cmd_we, input cmd_code, output rb_n, output dev_dq_out,
        output dev_dq_oe);
    modport host (output cmd_we, output cmd_code, input rb_n, input dev_dq_out,
        input dev_dq_oe);
endinterface : icc_if

// *** hw/icc_cal_engine.sv ***
// Purpose: Stepping calibration engine for driver and termination codes
// Assumes: cmp_above is an analog comparator result from the pad
// Notes: one LSB step per cycle, alternating driver and termination
`timescale 1ns/1ns
module icc_cal_engine (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic start,
    input wire logic long_mode,
    input wire logic abort,
    input wire logic [icc_pkg::CNT_W-1:0] cycles,
    input wire logic cmp_above,
    output logic done,
    output logic current_en,
    output logic [icc_pkg::CODE_W-1:0] drv_code,
    output logic [icc_pkg::CODE_W-1:0] odt_code
);
    import icc_pkg::*;

    logic cmp_s1_reg, cmp_s2_reg;
    logic [CNT_W-1:0] cnt_reg, cnt_next;
    logic [CODE_W-1:0] drv_reg, drv_next, odt_reg, odt_next;
    logic cur_reg, cur_next, done_reg, done_next;

    // Saturating one-LSB step toward the reference
    function automatic logic [CODE_W-1:0] step_code(input logic [CODE_W-1:0] c,
        input logic up);
        if (up) begin
            step_code = (c == {CODE_W{1'b1}}) ? c : c + 1'b1;
        end else begin
            step_code = (c == '0) ? c : c - 1'b1;
        end
    endfunction : step_code

    // Next values of counter, codes and current path
    always_comb begin
        cnt_next = cnt_reg;
        drv_next = drv_reg;
        odt_next = odt_reg;
        cur_next = cur_reg;
        done_next = 1'b0;
        if (abort) begin
            cur_next = 1'b0;
            cnt_next = '0;
        end else if (start) begin
            cnt_next = cycles;
            cur_next = 1'b1;
            if (long_mode) begin
                drv_next = CODE_MID;
                odt_next = CODE_MID;
            end
        end else if (cur_reg) begin
            // One step per cycle covers far more than 1.5 % in a short run
            if (cnt_reg[0]) begin
                drv_next = step_code(drv_reg, cmp_s2_reg);
            end else begin
                odt_next = step_code(odt_reg, cmp_s2_reg);
            end
            if (cnt_reg <= 16'h0001) begin
                done_next = 1'b1;
                cur_next = 1'b0; // Current path off once done
                cnt_next = '0;
            end else begin
                cnt_next = cnt_reg - 1'b1;
            end
        end
    end

    // Registers and comparator synchroniser
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cmp_s1_reg <= 1'b0;
            cmp_s2_reg <= 1'b0;
            cnt_reg <= '0;
            drv_reg <= FACTORY_DRV_CODE;
            odt_reg <= FACTORY_ODT_CODE;
            cur_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            cmp_s1_reg <= cmp_above;
            cmp_s2_reg <= cmp_s1_reg;
            cnt_reg <= cnt_next;
            drv_reg <= drv_next;
            odt_reg <= odt_next;
            cur_reg <= cur_next;
            done_reg <= done_next;
        end
    end

    assign done = done_reg;
    assign current_en = cur_reg;
    assign drv_code = drv_reg;
    assign odt_code = odt_reg;
endmodule : icc_cal_engine

// *** hw/icc_host.sv ***
// Purpose: Host controller end issuing calibration and reset commands
// Assumes: device end on the same mclk
// Notes: requests while not ready are dropped, except a reset during calibration; watch the ready output
`timescale 1ns/1ns
module icc_host (
    input wire logic mclk,
    input wire logic sys_rst,
    icc_if.host link,
    input wire logic req_long,
    input wire logic req_short,
    input wire logic req_reset,
    input wire logic req_status,
    input wire logic peer_cal_busy,
    input wire logic shared_rb_low,
    output logic ready,
    output logic cal_active,
    output logic rerun_needed,
    output logic status_valid,
    output logic [7:0] status_byte
);
    import icc_pkg::*;

    typedef enum logic [2:0] {
        H_IDLE = 3'b000,
        H_WAIT_WB = 3'b001,
        H_WAIT_RB = 3'b010,
        H_WAIT_FIX = 3'b011,
        H_STATUS = 3'b100
    } icc_host_state_t;

    icc_host_state_t state_reg, state_next;
    logic [CNT_W-1:0] cnt_reg, cnt_next;
    logic long_reg, long_next, cal_reg, cal_next, rerun_reg, rerun_next;
    logic we_reg, we_next, rdy_reg, rdy_next, sv_reg, sv_next;
    logic [7:0] code_reg, code_next, stat_reg, stat_next;

    // Host sequencer next state
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        long_next = long_reg;
        cal_next = cal_reg;
        rerun_next = rerun_reg;
        we_next = 1'b0;
        code_next = code_reg;
        stat_next = stat_reg;
        sv_next = 1'b0;
        case (state_reg)
            H_IDLE: begin
                cal_next = 1'b0;
                // Calibrates only when asked, never on its own
                // No overlap with a peer sharing the resistor
                if ((req_long || req_short) && !peer_cal_busy) begin
                    we_next = 1'b1;
                    code_next = req_long ? CMD_LONG_CAL : CMD_SHORT_CAL;
                    long_next = req_long;
                    rerun_next = 1'b0;
                    cal_next = 1'b1; // Holds other channels off
                    cnt_next = BUSY_ASSERT_CYCLES;
                    state_next = H_WAIT_WB;
                end else if (req_reset) begin
                    we_next = 1'b1;
                    code_next = CMD_RESET;
                    cnt_next = BUSY_ASSERT_CYCLES;
                    state_next = H_WAIT_WB;
                end else if (req_status) begin
                    we_next = 1'b1;
                    code_next = CMD_READ_STATUS;
                    state_next = H_STATUS;
                end
            end
            H_WAIT_WB, H_WAIT_FIX, H_WAIT_RB: begin
                // Only a reset may interrupt; bus otherwise silent
                if (req_reset && cal_reg) begin
                    we_next = 1'b1;
                    code_next = CMD_RESET;
                    rerun_next = 1'b1; // Codes undefined, calibrate again
                    cal_next = 1'b0;
                    cnt_next = BUSY_ASSERT_CYCLES;
                    state_next = H_WAIT_WB;
                end else if (state_reg == H_WAIT_RB) begin
                    if (link.rb_n) begin
                        state_next = H_IDLE;
                    end
                end else if (cnt_reg > 16'h0001) begin
                    cnt_next = cnt_reg - 1'b1;
                end else if (state_reg == H_WAIT_WB && cal_reg && shared_rb_low) begin
                    // Busy line shared: wait the full calibration time
                    cnt_next = long_reg ? HOST_LONG_WAIT : HOST_SHORT_WAIT;
                    state_next = H_WAIT_FIX;
                end else begin
                    state_next = (state_reg == H_WAIT_FIX) ? H_IDLE : H_WAIT_RB;
                end
            end
            H_STATUS: begin
                if (link.dev_dq_oe) begin
                    stat_next = link.dev_dq_out;
                    sv_next = 1'b1;
                    state_next = H_IDLE;
                end
            end
            default: begin
                state_next = H_IDLE;
            end
        endcase
        rdy_next = (state_next == H_IDLE);
    end

    // Host registers
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state_reg <= H_WAIT_RB; // Device runs its initial long calibration
            cnt_reg <= '0;
            long_reg <= 1'b1;
            cal_reg <= 1'b1;
            rerun_reg <= 1'b0;
            we_reg <= 1'b0;
            code_reg <= 8'h00;
            stat_reg <= 8'h00;
            sv_reg <= 1'b0;
            rdy_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            long_reg <= long_next;
            cal_reg <= cal_next;
            rerun_reg <= rerun_next;
            we_reg <= we_next;
            code_reg <= code_next;
            stat_reg <= stat_next;
            sv_reg <= sv_next;
            rdy_reg <= rdy_next;
        end
    end

    assign link.cmd_we = we_reg;
    assign link.cmd_code = code_reg;
    assign ready = rdy_reg;
    assign cal_active = cal_reg;
    assign rerun_needed = rerun_reg;
    assign status_valid = sv_reg;
    assign status_byte = stat_reg;
endmodule : icc_host

// *** verif/icc_chk_sva.sv ***
// Purpose: Channel checks between host and device ends
// Assumes: one clock, sync reset
// Notes: busy run length counted from the taken command
`timescale 1ns/1ns
module icc_chk_sva (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic cmd_we,
    input wire logic [7:0] cmd_code,
    input wire logic rb_n,
    input wire logic [7:0] dev_dq_out,
    input wire logic dev_dq_oe
);
    import icc_pkg::*;
    logic is_rst;
    logic taken;
    logic [2:0] kind_reg;
    logic [2:0] kind_next;
    logic [15:0] len_reg;
    logic [15:0] len_next;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    // Kind of run: 1 long, 2 short, 3 reset, 4 abort
    always_comb begin
        is_rst = cmd_code == 8'hff || cmd_code == 8'hfa || cmd_code == 8'hfc;
        taken = cmd_we && (rb_n || is_rst);
        kind_next = kind_reg;
        len_next = rb_n ? len_reg : len_reg + 16'h0001;
        if (taken) begin
            len_next = 16'h0000;
            kind_next = !rb_n ? 3'h4 : cmd_code == 8'hf9 ? 3'h1 :
                cmd_code == 8'hd9 ? 3'h2 : is_rst ? 3'h3 : 3'h0;
        end
    end
    // Register kind and length
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            kind_reg <= 3'h0;
            len_reg <= 16'h0000;
        end else begin
            kind_reg <= kind_next;
            len_reg <= len_next;
        end
    end
    chk_busy_start: assert property (taken && kind_next != 3'h0 |=> !rb_n)
        else $error("busy not raised");
    chk_long_len: assert property ($rose(rb_n) && kind_reg == 3'h1 |->
        len_reg == LONG_CAL_CYCLES) else $error("long busy length");
    chk_short_len: assert property ($rose(rb_n) && kind_reg == 3'h2 |->
        len_reg == SHORT_CAL_CYCLES) else $error("short busy length");
    chk_reset_bound: assert property ($rose(rb_n) && kind_reg[2] |->
        len_reg < 16'h09c4) else $error("abort reset too long");
    chk_dq_quiet: assert property (!rb_n |-> !dev_dq_oe)
        else $error("data driven while busy");
    chk_bus_quiet: assert property (cmd_we && !rb_n |-> is_rst)
        else $error("command during busy");
    chk_status_reply: assert property (cmd_we && rb_n && cmd_code == 8'h70 |=>
        dev_dq_oe && dev_dq_out[STAT_READY_BIT] ##1 !dev_dq_oe) else $error("status reply");
    chk_init_long: assert property ($fell(sys_rst) |-> !rb_n [*8])
        else $error("no initial calibration");
endmodule : icc_chk_sva

// *** verif/tb_top.sv ***
// Purpose: Bench joining host and device ends
// Assumes: mclk 250 MHz, sync reset
// Notes: requests are one-cycle pulses at ready, except the aborting resets
`timescale 1ns/1ns
module tb_top;
    import icc_pkg::*;
    logic mclk;
    logic sys_rst;
    logic [3:0] reqs;
    logic peer;
    logic shared_low;
    logic cmp_above;
    logic array_req;
    logic array_go;
    logic cur_en;
    logic cal_valid;
    logic [5:0] drv_code;
    logic [5:0] odt_code;
    logic ready;
    logic cal_active;
    logic rerun;
    logic status_valid;
    logic [7:0] status_byte;
    int error_cnt;
    int num_checks;
    icc_if i_icc_if ();
    icc_device i_icc_device (.mclk(mclk), .sys_rst(sys_rst), .link(i_icc_if),
        .cmp_above(cmp_above), .array_req(array_req), .array_go(array_go),
        .cal_current_en(cur_en), .cal_valid(cal_valid), .drv_code(drv_code),
        .odt_code(odt_code));
    icc_host i_icc_host (.mclk(mclk), .sys_rst(sys_rst), .link(i_icc_if),
        .req_long(reqs[3]), .req_short(reqs[2]), .req_reset(reqs[1]),
        .req_status(reqs[0]), .peer_cal_busy(peer), .shared_rb_low(shared_low),
        .ready(ready), .cal_active(cal_active), .rerun_needed(rerun),
        .status_valid(status_valid), .status_byte(status_byte));
    icc_chk_sva i_icc_chk_sva (.mclk(mclk), .sys_rst(sys_rst), .cmd_we(i_icc_if.cmd_we),
        .cmd_code(i_icc_if.cmd_code), .rb_n(i_icc_if.rb_n),
        .dev_dq_out(i_icc_if.dev_dq_out), .dev_dq_oe(i_icc_if.dev_dq_oe));
    // Clock
    always #2 mclk = ~mclk;
    task automatic end_sim;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s exp %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic send(input logic [3:0] r);
        @(negedge mclk);
        reqs = r;
        @(negedge mclk);
        reqs = 4'h0;
    endtask : send
    task automatic wait_ready(output int n);
        for (n = 0; ready !== 1'b1 && n < 3000; n++)
            @(negedge mclk);
        if (n >= 3000) begin
            chk("ready_timeout", 8'h01, 8'h00);
            end_sim();
        end
    endtask : wait_ready
    task automatic abort_run(input logic [3:0] r);
        send(r);
        repeat (40) @(negedge mclk);
        send(4'h2);
        repeat (4) @(negedge mclk);
    endtask : abort_run
    task automatic t_init;
        int n;
        wait_ready(n);
        chk("rb_n", i_icc_if.rb_n, 1);
        chk("cal_valid", cal_valid, 1);
        chk("cur_en", cur_en, 0);
        chk("drv_moved", drv_code !== FACTORY_DRV_CODE, 1);
        $display("test init done");
    endtask : t_init
    task automatic t_long;
        int n;
        array_req = 1'b1;
        send(4'h8);
        repeat (20) @(negedge mclk);
        chk("busy", i_icc_if.rb_n, 0);
        chk("array_go", array_go, 0);
        chk("cal_active", cal_active, 1);
        chk("cur_on", cur_en, 1);
        wait_ready(n);
        chk("cur_off", cur_en, 0);
        chk("odt_moved", odt_code !== FACTORY_ODT_CODE, 1);
        chk("array_idle", array_go, 1);
        array_req = 1'b0;
        $display("test long done");
    endtask : t_long
    task automatic t_status;
        int n;
        send(4'h1);
        for (n = 0; status_valid !== 1'b1 && n < 10; n++)
            @(negedge mclk);
        chk("stat_seen", n < 10, 1);
        chk("stat_ready", status_byte[STAT_READY_BIT], 1);
        chk("stat_valid", status_byte[STAT_CAL_VALID_BIT], 1);
        $display("test status done");
    endtask : t_status
    task automatic t_short_shared;
        int n;
        shared_low = 1'b1;
        cmp_above = 1'b0;
        send(4'h4);
        wait_ready(n);
        chk("shared_wait", n >= BUSY_ASSERT_CYCLES + SHORT_CAL_CYCLES, 1);
        chk("short_valid", cal_valid, 1);
        chk("short_drv", drv_code, 6'h20);
        chk("short_odt", odt_code, 6'h20);
        shared_low = 1'b0;
        $display("test short done");
    endtask : t_short_shared
    task automatic t_peer;
        peer = 1'b1;
        send(4'h8);
        repeat (10) @(negedge mclk);
        chk("peer_rb", i_icc_if.rb_n, 1);
        chk("peer_ready", ready, 1);
        peer = 1'b0;
        $display("test peer done");
    endtask : t_peer
    task automatic t_abort_long;
        int n;
        abort_run(4'h8);
        chk("drv_fact", drv_code, FACTORY_DRV_CODE);
        chk("odt_fact", odt_code, FACTORY_ODT_CODE);
        chk("valid_clr", cal_valid, 0);
        chk("rerun", rerun, 1);
        wait_ready(n);
        chk("rst_time", n < 2500, 1);
        $display("test abort long done");
    endtask : t_abort_long
    task automatic t_abort_short;
        int n;
        abort_run(4'h4);
        chk("drv_vend", drv_code, VENDOR_DRV_CODE);
        chk("odt_vend", odt_code, VENDOR_ODT_CODE);
        chk("fa_is_reset", icc_is_reset(8'hfa), 1);
        chk("fc_is_reset", icc_is_reset(8'hfc), 1);
        wait_ready(n);
        chk("rst_time", n < 2500, 1);
        $display("test abort short done");
    endtask : t_abort_short
    task automatic t_rerun;
        int n;
        send(4'h8);
        repeat (30) @(negedge mclk);
        sys_rst = 1'b1;
        repeat (2) @(negedge mclk);
        sys_rst = 1'b0;
        wait_ready(n);
        chk("rerun_clr", rerun, 0);
        chk("init_valid", cal_valid, 1);
        $display("test rerun done");
    endtask : t_rerun
    // Main sequence
    initial begin
        mclk = 1'b0;
        sys_rst = 1'b1;
        reqs = 4'h0;
        peer = 1'b0;
        shared_low = 1'b0;
        cmp_above = 1'b1;
        array_req = 1'b0;
        error_cnt = 0;
        num_checks = 0;
        repeat (6) @(negedge mclk);
        sys_rst = 1'b0;
        t_init();
        t_long();
        t_status();
        t_short_shared();
        t_peer();
        t_abort_long();
        t_abort_short();
        t_rerun();
        end_sim();
    end
endmodule : tb_top
